// [rtl/adf_decim_filter.sv]
// Decimation filter core: fast path, sinc3, sinc1 and high-pass stage
//
// Summary of operation
// - Each bit feeds a fast path and a sinc3 path; output picks one.
// - After reset conversions come from the first-order fast path.
// - After two conversions switch to sinc3 and stay until reset.
// - Ratios 128 to 1024 run sinc3 at that ratio, output direct.
// - Ratios 2048 up: sinc3 fixed at 1024, sinc1 decimates by 2..16.
// - Sinc3 is three integrators and three combs, cube of sinc.
// - Box-car combs null multiples of the data rate.
// - Restart events restart settling; unsettled words still delivered.
// - Settling time in clock cycles follows the ratio table.
// - Non-zero cutoff field enables the high-pass; zero bypasses all.
// - A per-channel bypass bit skips the high-pass stage.
// - High-pass coefficient is two to minus (field plus one).
// - High-pass updates once per output word.
// - Modulator bits arrive every second clock cycle.
// - A three-bit field selects ratio 128 through 16384.
`timescale 1ns/100ps
`include "adf_cfg.svh"
module adf_decim_filter #(
    parameter int unsigned SETTLE_2048  = `ADF_SETTLE_2048,
    parameter int unsigned SETTLE_4096  = `ADF_SETTLE_4096,
    parameter int unsigned SETTLE_8192  = `ADF_SETTLE_8192,
    parameter int unsigned SETTLE_16384 = `ADF_SETTLE_16384
) (
    // Clock and reset
    input wire logic         clock,
    input wire logic         reset,
    // Modulator bitstream
    input wire logic         mod_bit,
    // Register port
    input wire logic [3:0]   reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_write,
    input wire logic         reg_read,
    output logic     [31:0]  reg_rdata,
    // Data ready
    output logic             data_ready_n
);
    // ---------------------------------------------------------------
    // Decoding helpers
    // ---------------------------------------------------------------
    function automatic logic [3:0] total_log2(input logic [2:0] sel);
        return 4'h7 + {1'b0, sel};
    endfunction

    function automatic logic [3:0] sinc3_log2(input logic [2:0] sel);
        return sel[2] ? 4'ha : 4'h7 + {1'b0, sel};
    endfunction

    function automatic logic [13:0] ones_mask(input logic [3:0] k);
        return (14'h1 << k) - 14'h1;
    endfunction

    function automatic logic [15:0] settle_limit(input logic [2:0] sel);
        case (sel)
            3'h0:    return 16'(`ADF_SETTLE_128);
            3'h1:    return 16'(`ADF_SETTLE_256);
            3'h2:    return 16'(`ADF_SETTLE_512);
            3'h3:    return 16'(`ADF_SETTLE_1024);
            3'h4:    return 16'(SETTLE_2048);
            3'h5:    return 16'(SETTLE_4096);
            3'h6:    return 16'(SETTLE_8192);
            default: return 16'(SETTLE_16384);
        endcase
    endfunction

    function automatic logic [23:0] norm24(input logic signed [55:0] v,
                                           input logic [4:0] sh);
        logic signed [55:0] t;
        t = v >>> sh;
        if (t > 56'sh00_0000_007f_ffff) begin
            return 24'h7f_ffff;
        end else if (t < 56'shff_ffff_ff80_0000) begin
            return 24'h80_0000;
        end
        return t[23:0];
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic                phase_reg, phase_next;
    logic [2:0]          ratio_reg, ratio_next;
    logic                en_reg, en_next, byp_reg, byp_next;
    logic [2:0]          gain_reg, gain_next;
    logic [1:0]          mux_reg, mux_next;
    logic [3:0]          cut_reg, cut_next;
    logic                ovf_reg, ovf_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic                data_ready_n_n_reg;
    logic [13:0]         cnt_reg, cnt_next;
    logic signed [33:0]  i1_reg, i2_reg, i3_reg, i1_next, i2_next, i3_next;
    logic signed [33:0]  d1_reg, d2_reg, d3_reg, d1_next, d2_next, d3_next;
    logic signed [15:0]  fast_reg, fast_next;
    logic signed [28:0]  s1_reg, s1_next;
    logic [1:0]          conv_reg, conv_next;
    adf_pkg::adf_path_t  path_reg, path_next;
    logic [15:0]         settle_reg, settle_next;
    logic signed [39:0]  est_reg, est_next;
    logic                pend_reg, pend_next;
    logic [23:0]         pend_d_reg, pend_d_next;

    // ---------------------------------------------------------------
    // Combinational datapath
    // ---------------------------------------------------------------
    logic                samp_tick, s3_tick, conv_tick, restart, hp_off;
    logic signed [33:0]  x, c1, c2, c3;
    logic [23:0]         y3, y1, word;
    logic signed [39:0]  err;
    logic [3:0]          k3, kt;
    logic                wr_chan;

    adf_fifo_if #(.WIDTH(`ADF_WORD_W)) fq ();

    adf_fifo #(.WIDTH(`ADF_WORD_W), .DEPTH(`ADF_FIFO_DEPTH)) u_fifo (
        .clock (clock),
        .reset (reset),
        .f     (fq.fifo_side)
    );

    assign fq.push_valid = pend_reg;
    assign fq.push_data  = pend_d_reg;
    assign fq.pop_ready  = reg_read && (reg_addr == `ADF_ADDR_DATA);

    always_comb begin
        phase_next  = ~phase_reg;
        ratio_next  = ratio_reg;
        en_next     = en_reg;
        byp_next    = byp_reg;
        gain_next   = gain_reg;
        mux_next    = mux_reg;
        cut_next    = cut_reg;
        rdata_next  = 32'h0;
        wr_chan     = reg_write && (reg_addr == `ADF_ADDR_CHAN);
        restart     = !en_reg;
        k3          = sinc3_log2(ratio_reg);
        kt          = total_log2(ratio_reg);
        samp_tick   = phase_reg;
        s3_tick     = samp_tick && ((cnt_reg & ones_mask(k3)) == ones_mask(k3));
        conv_tick   = samp_tick && (cnt_reg == ones_mask(kt));
        x           = mod_bit ? 34'sh1 : 34'sh3_ffff_ffff;
        i1_next     = i1_reg + x;
        i2_next     = i2_reg + i1_next;
        i3_next     = i3_reg + i2_next;
        c1          = i3_next - d1_reg;
        c2          = c1 - d2_reg;
        c3          = c2 - d3_reg;
        y3          = norm24(56'(c3) <<< 23, 5'(3 * k3));
        y1          = 24'(s1_reg + 29'(signed'(y3)) >>> (kt - k3));
        // fast path accumulates a plain box-car
        fast_next   = fast_reg + 16'(x);
        d1_next     = d1_reg;
        d2_next     = d2_reg;
        d3_next     = d3_reg;
        s1_next     = s1_reg;
        cnt_next    = cnt_reg;
        conv_next   = conv_reg;
        path_next   = path_reg;
        est_next    = est_reg;
        pend_next   = pend_reg && !fq.push_ready;
        pend_d_next = pend_d_reg;
        ovf_next    = ovf_reg;
        word        = y3;
        err         = 40'sh0;
        hp_off      = (cut_reg == 4'h0) || byp_reg;
        settle_next = (settle_reg == 16'hffff) ? settle_reg : settle_reg + 16'h1;

        if (reg_write) begin
            case (reg_addr)
                `ADF_ADDR_CTRL: restart = restart || reg_wdata[`ADF_CTRL_RESYNC];
                `ADF_ADDR_CLK:  ratio_next = reg_wdata[2:0];
                `ADF_ADDR_THR:  cut_next = reg_wdata[3:0];
                `ADF_ADDR_STAT: ovf_next = ovf_reg && !reg_wdata[`ADF_STAT_OVF];
                default: ;
            endcase
        end
        if (wr_chan) begin
            en_next   = reg_wdata[`ADF_CHAN_EN];
            byp_next  = reg_wdata[`ADF_CHAN_BYP];
            gain_next = reg_wdata[`ADF_CHAN_GAIN_LO +: 3];
            mux_next  = reg_wdata[`ADF_CHAN_MUX_LO +: 2];
        end
        // enable, gain, mux or ratio change restarts
        if ((en_next && !en_reg) || gain_next != gain_reg || mux_next != mux_reg ||
            ratio_next != ratio_reg) begin
            restart = 1'b1;
        end

        if (s3_tick) begin
            d1_next = i3_next;
            d2_next = c1;
            d3_next = c2;
            s1_next = (cnt_reg == ones_mask(kt)) ? 29'sh0 : s1_reg + 29'(signed'(y3));
        end
        if (conv_tick) begin
            if (path_reg == adf_pkg::PATH_FAST) begin
                word = norm24(56'(fast_next) <<< 23, 5'(kt));
            end else if (ratio_reg[2]) begin
                word = y1;
            end else begin
                word = y3;
            end
            if (conv_reg != `ADF_FAST_CONVS) begin
                conv_next = conv_reg + 2'h1;
            end
            if (conv_next == `ADF_FAST_CONVS) begin
                path_next = adf_pkg::PATH_SINC3;
            end
            // coefficient two to minus field plus one
            if (!hp_off) begin
                err      = {word, 16'h0} - est_reg;
                est_next = est_reg + (err >>> ({1'b0, cut_reg} + 5'h1));
                word     = err[39:16];
            end
            ovf_next    = ovf_next || (pend_reg && !fq.push_ready);
            pend_next   = 1'b1;
            pend_d_next = word;
        end
        if (samp_tick) begin
            cnt_next  = conv_tick ? 14'h0 : cnt_reg + 14'h1;
            fast_next = conv_tick ? 16'sh0 : fast_next;
        end else begin
            i1_next   = i1_reg;
            i2_next   = i2_reg;
            i3_next   = i3_reg;
            fast_next = fast_reg;
        end
        if (restart) begin
            cnt_next    = 14'h0;
            i1_next     = 34'sh0;
            i2_next     = 34'sh0;
            i3_next     = 34'sh0;
            d1_next     = 34'sh0;
            d2_next     = 34'sh0;
            d3_next     = 34'sh0;
            s1_next     = 29'sh0;
            fast_next   = 16'sh0;
            settle_next = 16'h0;
        end

        if (reg_read) begin
            case (reg_addr)
                `ADF_ADDR_CLK:  rdata_next = {29'h0, ratio_reg};
                `ADF_ADDR_CHAN: rdata_next = {25'h0, mux_reg, gain_reg, byp_reg, en_reg};
                `ADF_ADDR_THR:  rdata_next = {28'h0, cut_reg};
                `ADF_ADDR_STAT: begin
                    rdata_next = {28'h0, fq.pop_valid, ovf_reg,
                                  settle_reg >= settle_limit(ratio_reg),
                                  path_reg == adf_pkg::PATH_FAST};
                end
                `ADF_ADDR_DATA: begin
                    rdata_next = fq.pop_valid ? {{8{fq.pop_data[23]}}, fq.pop_data} : 32'h0;
                end
                default: rdata_next = 32'h0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg  <= 1'b0;
            ratio_reg  <= `ADF_RST_RATIO;
            en_reg     <= `ADF_RST_EN;
            byp_reg    <= 1'b0;
            gain_reg   <= 3'h0;
            mux_reg    <= 2'h0;
            cut_reg    <= `ADF_RST_CUTOFF;
            ovf_reg    <= 1'b0;
            rdata_reg  <= 32'h0;
            data_ready_n_n_reg <= 1'b1;
            cnt_reg    <= 14'h0;
            {i1_reg, i2_reg, i3_reg, d1_reg, d2_reg, d3_reg} <= '0;
            fast_reg   <= 16'sh0;
            s1_reg     <= 29'sh0;
            conv_reg   <= 2'h0;
            path_reg   <= adf_pkg::PATH_FAST;
            settle_reg <= 16'h0;
            est_reg    <= 40'sh0;
            pend_reg   <= 1'b0;
            pend_d_reg <= 24'h0;
        end else begin
            phase_reg  <= phase_next;
            ratio_reg  <= ratio_next;
            en_reg     <= en_next;
            byp_reg    <= byp_next;
            gain_reg   <= gain_next;
            mux_reg    <= mux_next;
            cut_reg    <= cut_next;
            ovf_reg    <= ovf_next;
            rdata_reg  <= rdata_next;
            data_ready_n_n_reg <= !fq.pop_valid;
            cnt_reg    <= cnt_next;
            i1_reg     <= i1_next;
            i2_reg     <= i2_next;
            i3_reg     <= i3_next;
            d1_reg     <= d1_next;
            d2_reg     <= d2_next;
            d3_reg     <= d3_next;
            fast_reg   <= fast_next;
            s1_reg     <= s1_next;
            conv_reg   <= conv_next;
            path_reg   <= path_next;
            settle_reg <= settle_next;
            est_reg    <= est_next;
            pend_reg   <= pend_next;
            pend_d_reg <= pend_d_next;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign data_ready_n = data_ready_n_n_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    AST_MOD_RATE: assert property (samp_tick |=> !samp_tick)
        else $error("modulator tick not every second clock");
    AST_FAST_FIRST: assert property (
        conv_reg < 2'h2 |-> path_reg == adf_pkg::PATH_FAST)
        else $error("fast path left too early");
    AST_SWITCH: assert property (
        conv_tick && conv_reg == 2'h1 |=> path_reg == adf_pkg::PATH_SINC3)
        else $error("no switch after second conversion");
    AST_STAY: assert property (
        path_reg == adf_pkg::PATH_SINC3 |=> path_reg == adf_pkg::PATH_SINC3)
        else $error("sinc3 path left");
    AST_RESTART_CLR: assert property (
        restart |=> cnt_reg == 14'h0 && i3_reg == 34'sh0 && settle_reg == 16'h0)
        else $error("restart did not clear state");
    AST_SINC3_CAP: assert property (
        s3_tick && ratio_reg[2] |-> cnt_reg[9:0] == 10'h3ff)
        else $error("sinc3 not at fixed 1024");
    AST_CONV_PERIOD: assert property (
        conv_tick |-> cnt_reg == ones_mask(total_log2(ratio_reg)))
        else $error("conversion period wrong");
    AST_DELIVER: assert property (conv_tick |=> pend_reg)
        else $error("conversion word not delivered");
    AST_BYPASS: assert property (
        conv_tick && hp_off |=> $stable(est_reg))
        else $error("bypassed high-pass changed estimate");
    AST_HP_RATE: assert property (!conv_tick |=> $stable(est_reg))
        else $error("high-pass updated between words");
    AST_SETTLE_TIME: assert property (
        restart ##1 (!restart && !reset)[*8] |-> settle_reg == 16'h7)
        else $error("settle counter not counting clocks");

    COV_SWITCH: cover property (conv_tick && conv_reg == 2'h1);
    COV_OVF: cover property ($rose(ovf_reg));
    COV_HP: cover property (conv_tick && !hp_off);
    COV_SINC1: cover property (conv_tick && ratio_reg[2]);
endmodule

// [rtl/adf_cfg.svh]
// Offsets, field positions, reset values and timing counts of the filter
`ifndef ADF_CFG_SVH
`define ADF_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADF_ADDR_CTRL    4'h0
`define ADF_ADDR_CLK     4'h1
`define ADF_ADDR_CHAN    4'h2
`define ADF_ADDR_THR     4'h3
`define ADF_ADDR_STAT    4'h4
`define ADF_ADDR_DATA    4'h5

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ADF_CTRL_RESYNC  0
`define ADF_CHAN_EN      0
`define ADF_CHAN_BYP     1
`define ADF_CHAN_GAIN_LO 2
`define ADF_CHAN_MUX_LO  5
`define ADF_STAT_FAST    0
`define ADF_STAT_SETTLED 1
`define ADF_STAT_OVF     2
`define ADF_STAT_AVAIL   3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ADF_RST_RATIO    3'h3
`define ADF_RST_CUTOFF   4'h0
`define ADF_RST_EN       1'b1

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define ADF_SETTLE_128   856
`define ADF_SETTLE_256   1112
`define ADF_SETTLE_512   1624
`define ADF_SETTLE_1024  2648
`define ADF_SETTLE_2048  4696
`define ADF_SETTLE_4096  8792
`define ADF_SETTLE_8192  16984
`define ADF_SETTLE_16384 33368
`define ADF_FAST_CONVS   2'h2
`define ADF_FIFO_DEPTH   8
`define ADF_WORD_W       24

`endif

// [rtl/adf_pkg.sv]
// Types shared by the decimation filter modules
package adf_pkg;
    typedef enum logic {PATH_FAST, PATH_SINC3} adf_path_t;
endpackage

// [rtl/adf_fifo_if.sv]
// Stream carrier between the filter core and its output FIFO
`timescale 1ns/100ps
interface adf_fifo_if #(parameter int WIDTH = 24);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport fifo_side (input push_valid, push_data, pop_ready,
                       output push_ready, pop_valid, pop_data);
    modport user_side (output push_valid, push_data, pop_ready,
                       input push_ready, pop_valid, pop_data);
endinterface

// [rtl/adf_fifo.sv]
// Flip-flop FIFO holding finished conversion words
`timescale 1ns/100ps
module adf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic     clock,
    input wire logic     reset,
    // Stream
    adf_fifo_if.fifo_side f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign f.push_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign f.pop_valid  = (cnt_reg != '0);
    assign f.pop_data   = mem_reg[rd_reg];
    assign push         = f.push_valid && f.push_ready;
    assign pop          = f.pop_ready && f.pop_valid;

    always_comb begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wr_reg] = f.push_data;
            wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_next = cnt_reg - (AW+1)'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
        mem_reg <= mem_next;
    end

    AST_FIFO_BOUND: assert property (@(posedge clock) disable iff (reset)
        cnt_reg <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

// [sim/adf_mod_model.sv]
// Modulator bitstream source: constant zeros or an alternating pattern
`timescale 1ns/100ps
module adf_mod_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Pattern select: 0 zeros, 1 alternating
    input wire logic alternate,
    // Bitstream
    output logic     mod_bit
);
    logic [1:0] phase_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign mod_bit = alternate & phase_reg[1];
endmodule

// [sim/adc_decimation_and_dc_block_filter_test.sv]
// Self-checking bench of the decimation filter core
`timescale 1ns/100ps
`include "adf_cfg.svh"
module adc_decimation_and_dc_block_filter_test;
    logic        clock;
    logic        reset;
    logic        mod_bit;
    logic        alternate;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic        data_ready_n;
    logic [31:0] d;
    int          err_count;
    int          samples_checked;
    int          n;

    adf_decim_filter #(.SETTLE_2048(40), .SETTLE_4096(40), .SETTLE_8192(40),
                       .SETTLE_16384(40)) uut (
        .clock(clock), .reset(reset), .mod_bit(mod_bit), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .data_ready_n(data_ready_n));
    adf_mod_model modm (.clock(clock), .reset(reset), .alternate(alternate),
                        .mod_bit(mod_bit));

    // ---------------------------------------------------------------
    // Bus tasks and checks
    // ---------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait for a word; n holds the cycles waited
    task automatic wait_word(input int lim);
        n = 0;
        while (data_ready_n !== 1'b0 && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("data ready low", 32'h0, {31'h0, data_ready_n});
    endtask

    task automatic drain();
        while (data_ready_n === 1'b0) begin
            rd(`ADF_ADDR_DATA);
            repeat (2) @(posedge clock);
            #1;
        end
    endtask

    task automatic next_word(input int lim);
        drain();
        wait_word(lim);
        rd(`ADF_ADDR_DATA);
    endtask

    task automatic wrap_up();
        $display("TB: checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Clock, watchdog and tests
    // ---------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (80000) @(posedge clock);
        err_count++;
        $display("ERROR watchdog expected finish seen timeout");
        wrap_up();
    end

    initial begin
        reset = 1'b1;
        alternate = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        rd(`ADF_ADDR_CLK);
        chk("ratio reset", {29'h0, `ADF_RST_RATIO}, d);
        rd(`ADF_ADDR_THR);
        chk("cutoff reset", 32'h0, d);
        rd(4'hf);
        chk("unmapped read", 32'h0, d);
        rd(`ADF_ADDR_STAT);
        chk("fast flag", 32'h1, d & 32'h1);
        $display("TB: reset test done");
        wr(`ADF_ADDR_CLK, 32'h0);
        wait_word(400);
        chk("period 128", 32'h1, {31'h0, n > 240 && n < 300});
        rd(`ADF_ADDR_DATA);
        chk("fast word", 32'h0, d);
        next_word(400);
        chk("fast word 2", 32'h0, d);
        rd(`ADF_ADDR_STAT);
        chk("sinc3 after two", 32'h0, d & 32'h1);
        alternate <= 1'b0;
        repeat (6) next_word(400);
        chk("sinc3 full scale", 32'hff800000, d);
        rd(`ADF_ADDR_STAT);
        chk("still sinc3", 32'h2, d & 32'h3);
        $display("TB: path test done");
        drain();
        wr(`ADF_ADDR_CTRL, 32'h1);
        wait_word(300);
        repeat (760 - n) @(posedge clock);
        rd(`ADF_ADDR_STAT);
        chk("unsettled", 32'h0, d & 32'h2);
        repeat (100) @(posedge clock);
        rd(`ADF_ADDR_STAT);
        chk("settled", 32'h2, d & 32'h2);
        // Host side: words before the settled flag are thrown away
        drain();
        $display("TB: resync test done");
        wr(`ADF_ADDR_THR, 32'h1);
        repeat (60) next_word(400);
        chk("highpass residual", 32'h1,
            {31'h0, $signed(d) > -32 && $signed(d) < 32});
        wr(`ADF_ADDR_CHAN, 32'h3);
        next_word(400);
        chk("channel bypass", 32'hff800000, d);
        $display("TB: highpass test done");
        repeat (2700) @(posedge clock);
        rd(`ADF_ADDR_STAT);
        chk("overflow set", 32'h4, d & 32'h4);
        wr(`ADF_ADDR_STAT, 32'h4);
        rd(`ADF_ADDR_STAT);
        chk("overflow clear", 32'h0, d & 32'h4);
        $display("TB: overflow test done");
        drain();
        wr(`ADF_ADDR_CLK, 32'h4);
        wait_word(4400);
        chk("period 2048", 32'h1, {31'h0, n > 4000 && n < 4200});
        repeat (4) next_word(4400);
        chk("sinc1 full scale", 32'hff800000, d);
        $display("TB: ratio 2048 test done");
        wrap_up();
    end
endmodule
